// File: xfer_buffer.sv
`default_nettype none

// ----------------------------------------------------------------------------
// shared constants and types
// ----------------------------------------------------------------------------
package ptc_pkg;
  localparam int NUM_CH     = 8;
  localparam int NUM_PER    = 4;
  localparam int ADDR_W     = 32;
  localparam int CNT_W      = 16;
  localparam int DATA_W     = 16;
  localparam int CH_IDX_W   = 3;
  localparam int BUF_DEPTH  = 2;
  // channel 2k serves the receive path of peripheral k, 2k+1 its transmit path
  localparam int DIR_BIT    = 0;
  localparam logic [ADDR_W-1:0] STEP_BYTE  = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] STEP_HALF  = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] PTR_RESET  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;

  // one memory access queued by the engine
  typedef struct packed {
    logic                we;
    logic                wide;
    logic [CH_IDX_W-1:0] ch;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } mem_cmd_t;

  // state of the controller apart from the command buffer contents
  typedef struct packed {
    logic [NUM_CH-1:0][ADDR_W-1:0] ptr;
    logic [NUM_CH-1:0][CNT_W-1:0]  cnt;
    logic [NUM_CH-1:0]             done;
    logic [NUM_CH-1:0]             pend;
    logic [CH_IDX_W-1:0]           last;
    logic [NUM_CH-1:0]             ack;
    logic [DATA_W-1:0]             txd;
    logic                          mbusy;
    mem_cmd_t                      mcmd;
  } ctl_state_t;
endpackage

// ----------------------------------------------------------------------------
// two-entry command buffer with valid/ready on both sides
// ----------------------------------------------------------------------------
module xfer_buffer #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wptr;
    logic [PW-1:0]           rptr;
    logic [PW:0]             fill;
  } buf_state_t;

  buf_state_t s_r;
  buf_state_t s_nxt;
  logic       do_push;
  logic       do_pop;

  // honest full and empty flags
  assign in_ready_o  = (32'(s_r.fill) < DEPTH);
  assign out_valid_o = (s_r.fill != '0);
  assign out_data_o  = s_r.mem[s_r.rptr];
  assign do_push     = in_valid_i && in_ready_o;
  assign do_pop      = out_valid_o && out_ready_i;

  // pointer and fill update
  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wptr] = in_data_i;
      s_nxt.wptr          = (32'(s_r.wptr) == DEPTH - 1) ? '0 : s_r.wptr + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rptr = (32'(s_r.rptr) == DEPTH - 1) ? '0 : s_r.rptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      s_nxt.fill = s_r.fill + 1'b1;
    end else if (do_pop && !do_push) begin
      s_nxt.fill = s_r.fill - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

`default_nettype wire

// File: peripheral_transfer_controller.sv
// Summary of operation
// (R1) Eight independent channels all serve the three serial ports and the one SPI.
// (R2) Each peripheral owns two channels, receive on the even index and transmit on the odd.
// (R3) Each channel holds a writable 32-bit memory pointer and a 16-bit remaining count.
// (R4) When a channel's count runs out its end flag rises for the owning peripheral's interrupt.
// (R5) One programming moves up to 64K contiguous items with no rewrite of the start address.
// (R6) Data moves between peripherals and memory with no processor action per item.
// (R7) Pointer and count are written and read through each peripheral's own register port.
// (R8) The peripherals hand data straight to the controller over per-channel request/ack lines.
// (R9) Each item advances the pointer by the item size and drops the count by one, stopping at zero.
`default_nettype none

module peripheral_transfer_controller (
  input  wire logic                                               REF_CLK_I,
  input  wire logic                                               RSTN_I,
  input  wire logic [ptc_pkg::NUM_CH-1:0]                         CH_WR_PTR_I,
  input  wire logic [ptc_pkg::NUM_CH-1:0]                         CH_WR_CNT_I,
  input  wire logic [ptc_pkg::ADDR_W-1:0]                         CH_WDATA_I,
  input  wire logic [ptc_pkg::NUM_CH-1:0]                         CH_WIDE_I,
  output logic      [ptc_pkg::NUM_CH-1:0][ptc_pkg::ADDR_W-1:0]    CH_PTR_O,
  output logic      [ptc_pkg::NUM_CH-1:0][ptc_pkg::CNT_W-1:0]     CH_CNT_O,
  output logic      [ptc_pkg::NUM_CH-1:0]                         CH_END_O,
  input  wire logic [ptc_pkg::NUM_CH-1:0]                         PER_REQ_I,
  input  wire logic [ptc_pkg::NUM_PER-1:0][ptc_pkg::DATA_W-1:0]   PER_RDATA_I,
  output logic      [ptc_pkg::NUM_CH-1:0]                         PER_ACK_O,
  output logic      [ptc_pkg::DATA_W-1:0]                         PER_WDATA_O,
  output logic                                                    MEM_REQ_O,
  output logic                                                    MEM_WE_O,
  output logic                                                    MEM_WIDE_O,
  output logic      [ptc_pkg::ADDR_W-1:0]                         MEM_ADDR_O,
  output logic      [ptc_pkg::DATA_W-1:0]                         MEM_WDATA_O,
  input  wire logic [ptc_pkg::DATA_W-1:0]                         MEM_RDATA_I,
  input  wire logic                                               MEM_ACK_I
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------

  // pointer increment for one item, byte or halfword
  // a byte moves the address by one, a halfword by two
  function automatic logic [ptc_pkg::ADDR_W-1:0] item_step(input logic wide);
    item_step = wide ? ptc_pkg::STEP_HALF : ptc_pkg::STEP_BYTE;
  endfunction

  // true for a channel attached to a transmit path
  // even channels receive, odd channels transmit
  function automatic logic is_tx(input logic [ptc_pkg::CH_IDX_W-1:0] ch);
    is_tx = ch[ptc_pkg::DIR_BIT];
  endfunction

  // peripheral that owns a channel
  function automatic logic [ptc_pkg::CH_IDX_W-2:0] per_of(
    input logic [ptc_pkg::CH_IDX_W-1:0] ch
  );
    per_of = ch[ptc_pkg::CH_IDX_W-1:1];
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  // (R3) pointers and counts live in the state struct
  ptc_pkg::ctl_state_t s_r;
  ptc_pkg::ctl_state_t s_nxt;

  // engine side of the command buffer
  ptc_pkg::mem_cmd_t   push_cmd;
  logic                push_valid;
  logic                push_ready;

  // memory side of the command buffer
  ptc_pkg::mem_cmd_t   head_cmd;
  logic                head_valid;
  logic                head_ready;
  logic [$bits(ptc_pkg::mem_cmd_t)-1:0] head_bits;

  // channels allowed to queue an item this cycle
  logic [ptc_pkg::NUM_CH-1:0] elig;

  // --------------------------------------------------------------------------
  // command buffer between engine and memory port
  // --------------------------------------------------------------------------
  xfer_buffer #(
    .W     ($bits(ptc_pkg::mem_cmd_t)),
    .DEPTH (ptc_pkg::BUF_DEPTH)
  ) u_cmd_buf (
    .clk_i       (REF_CLK_I),
    .rstn_i      (RSTN_I),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_cmd),
    .out_valid_o (head_valid),
    .out_ready_i (head_ready),
    .out_data_o  (head_bits)
  );

  // buffer head seen as a command
  assign head_cmd   = ptc_pkg::mem_cmd_t'(head_bits);
  // memory stage takes a new command when idle or finishing this cycle
  assign head_ready = !s_r.mbusy || MEM_ACK_I;

  // --------------------------------------------------------------------------
  // per-channel eligibility
  // --------------------------------------------------------------------------
  // (R1) eight channels compete on equal terms
  for (genvar g = 0; g < ptc_pkg::NUM_CH; g++) begin : g_elig
    // (R9) stop at zero, one item in flight, never while written
    assign elig[g] = PER_REQ_I[g] && (s_r.cnt[g] != ptc_pkg::CNT_RESET) && !s_r.pend[g]
                     && !CH_WR_PTR_I[g] && !CH_WR_CNT_I[g];
  end

  // --------------------------------------------------------------------------
  // engine: channel registers, arbitration, memory stage
  // --------------------------------------------------------------------------
  always_comb begin
    logic                            found;
    logic [ptc_pkg::CH_IDX_W-1:0]    sel;
    logic [ptc_pkg::CH_IDX_W-1:0]    idx;
    // scratch for the round-robin search, then defaults
    found      = 1'b0;
    sel        = '0;
    idx        = '0;
    s_nxt      = s_r;
    s_nxt.ack  = '0;
    push_valid = 1'b0;
    push_cmd   = '0;

    // (R7) register port writes
    for (int i = 0; i < ptc_pkg::NUM_CH; i++) begin
      if (CH_WR_PTR_I[i]) begin
        s_nxt.ptr[i] = CH_WDATA_I;
      end
      if (CH_WR_CNT_I[i]) begin
        s_nxt.cnt[i]  = CH_WDATA_I[ptc_pkg::CNT_W-1:0];
        s_nxt.done[i] = (CH_WDATA_I[ptc_pkg::CNT_W-1:0] == ptc_pkg::CNT_RESET);
      end
    end

    // round-robin pick starting after the last served channel
    for (int k = 1; k <= ptc_pkg::NUM_CH; k++) begin
      idx = s_r.last + ptc_pkg::CH_IDX_W'(k);
      if (!found && elig[idx]) begin
        found = 1'b1;
        sel   = idx;
      end
    end

    // memory stage completion, clears pending before any new set
    if (s_r.mbusy && MEM_ACK_I) begin
      s_nxt.pend[s_r.mcmd.ch] = 1'b0;
      s_nxt.mbusy             = 1'b0;
      // (R2) transmit delivery
      if (!s_r.mcmd.we) begin
        s_nxt.txd              = MEM_RDATA_I;
        s_nxt.ack[s_r.mcmd.ch] = 1'b1;
      end
    end

    // a full buffer leaves the request standing for a later cycle
    // (R6) queue one item without processor help
    if (found && push_ready) begin
      push_valid     = 1'b1;
      push_cmd.we    = !is_tx(sel);
      push_cmd.wide  = CH_WIDE_I[sel];
      push_cmd.ch    = sel;
      push_cmd.addr  = s_r.ptr[sel];
      // (R2) receive data from peripheral
      push_cmd.data  = PER_RDATA_I[per_of(sel)];
      s_nxt.pend[sel] = 1'b1;
      s_nxt.last      = sel;
      // (R9) pointer and count step
      s_nxt.ptr[sel]  = s_r.ptr[sel] + item_step(CH_WIDE_I[sel]);
      // (R5) contiguous 16-bit span
      s_nxt.cnt[sel]  = s_r.cnt[sel] - ptc_pkg::CNT_ONE;
      // (R4) end of transfer
      if (s_r.cnt[sel] == ptc_pkg::CNT_ONE) begin
        s_nxt.done[sel] = 1'b1;
      end
      // (R8) receive item taken
      if (!is_tx(sel)) begin
        s_nxt.ack[sel] = 1'b1;
      end
    end

    // load the memory stage from the buffer head
    if (head_ready && head_valid) begin
      s_nxt.mbusy = 1'b1;
      s_nxt.mcmd  = head_cmd;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all from state flops
  // --------------------------------------------------------------------------
  // register readback
  assign CH_PTR_O    = s_r.ptr;
  assign CH_CNT_O    = s_r.cnt;
  // (R4) end flag toward peripheral
  assign CH_END_O    = s_r.done;
  // peripheral handshake
  assign PER_ACK_O   = s_r.ack;
  assign PER_WDATA_O = s_r.txd;
  // memory port, held until acknowledged
  assign MEM_REQ_O   = s_r.mbusy;
  assign MEM_WE_O    = s_r.mcmd.we;
  assign MEM_WIDE_O  = s_r.mcmd.wide;
  assign MEM_ADDR_O  = s_r.mcmd.addr;
  assign MEM_WDATA_O = s_r.mcmd.data;

endmodule

`default_nettype wire

// File: ptc_props.sv
`default_nettype none
module ptc_props (
  input wire logic                  REF_CLK_I,
  input wire logic                  RSTN_I,
  input wire logic [7:0]            CH_WR_PTR_I,
  input wire logic [7:0]            CH_WR_CNT_I,
  input wire logic [31:0]           CH_WDATA_I,
  input wire logic [7:0]            CH_WIDE_I,
  input wire logic [7:0][31:0]      CH_PTR_O,
  input wire logic [7:0][15:0]      CH_CNT_O,
  input wire logic [7:0]            CH_END_O,
  input wire logic [7:0]            PER_ACK_O,
  input wire logic [15:0]           PER_WDATA_O,
  input wire logic                  MEM_REQ_O,
  input wire logic [31:0]           MEM_ADDR_O,
  input wire logic [15:0]           MEM_RDATA_I,
  input wire logic                  MEM_ACK_I
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_ptr_write: assert property (CH_WR_PTR_I[1] |=> CH_PTR_O[1] == $past(CH_WDATA_I))
    else $error("pointer write lost");
  a_cnt_write: assert property (CH_WR_CNT_I[0] |=> CH_CNT_O[0] == $past(CH_WDATA_I[15:0]))
    else $error("count write lost");
  a_end_zero: assert property (CH_WR_CNT_I[2] && CH_WDATA_I[15:0] == 16'h0000 |=> CH_END_O[2])
    else $error("zero count gives no end flag");
  a_end_rise: assert property ($rose(CH_END_O[0]) |-> CH_CNT_O[0] == 16'h0000)
    else $error("end flag with count left");
  a_rx_count: assert property (PER_ACK_O[0] |-> CH_CNT_O[0] == $past(CH_CNT_O[0]) - 16'h0001)
    else $error("count not dropped by one");
  a_rx_step: assert property (PER_ACK_O[0] |->
    CH_PTR_O[0] == $past(CH_PTR_O[0]) + ($past(CH_WIDE_I[0]) ? 32'h2 : 32'h1))
    else $error("pointer step wrong");
  a_zero_idle: assert property (CH_CNT_O[0] == 16'h0000 |=> !PER_ACK_O[0])
    else $error("empty channel served");
  a_ack_pulse: assert property (PER_ACK_O[0] |=> !PER_ACK_O[0])
    else $error("ack longer than one cycle");
  a_tx_data: assert property (PER_ACK_O[1] |-> $past(MEM_ACK_I) && PER_WDATA_O == $past(MEM_RDATA_I))
    else $error("tx data not from memory read");
  a_mem_hold: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
    else $error("memory request dropped early");
endmodule
bind peripheral_transfer_controller ptc_props ptc_props_i (.REF_CLK_I, .RSTN_I, .CH_WR_PTR_I,
  .CH_WR_CNT_I, .CH_WDATA_I, .CH_WIDE_I, .CH_PTR_O, .CH_CNT_O, .CH_END_O, .PER_ACK_O,
  .PER_WDATA_O, .MEM_REQ_O, .MEM_ADDR_O, .MEM_RDATA_I, .MEM_ACK_I);
`default_nettype wire

// File: ptc_mem_model.sv
`default_nettype none
module ptc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        wide_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             ack_o,
  output logic      [31:0] wr_addr_o,
  output logic      [15:0] wr_data_o,
  output logic             wr_wide_o,
  output logic      [7:0]  n_wr_o
);
  logic [3:0] wait_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {wait_r, ack_o, rdata_o, wr_addr_o, wr_data_o, wr_wide_o, n_wr_o} <= '0;
    end else begin
      ack_o <= req_i && !ack_o && wait_r == lat_i;
      wait_r <= (req_i && !ack_o && wait_r != lat_i) ? wait_r + 4'h1 : 4'h0;
      rdata_o <= (req_i && !ack_o && wait_r == lat_i) ? ~addr_i[15:0] : ~rdata_o; // no stale data
      if (ack_o && we_i) begin
        wr_addr_o <= addr_i;
        wr_data_o <= wdata_i;
        wr_wide_o <= wide_i;
        n_wr_o <= n_wr_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: test_peripheral_transfer_controller.sv
`default_nettype none
module test_peripheral_transfer_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0, rstn = 1'b0, mreq, mwe, mwide, mack, w_wide;
  logic [7:0]       wr_ptr = '0, wr_cnt = '0, req = '0, wide = 8'hCC, ack, end_f, n_wr, n0;
  logic [31:0]      wdata = '0, madr, w_adr, base, step;
  logic [3:0][15:0] prd = '0;
  logic [7:0][31:0] ptr;
  logic [7:0][15:0] cnt;
  logic [15:0]      pwd, mwd, mrd, w_dat;
  logic [3:0]       lat = 4'h0;
  int               n_fail = 0, cmp_count = 0, cyc = 0, k;
  peripheral_transfer_controller peripheral_transfer_controller_i (.REF_CLK_I(clk),
    .RSTN_I(rstn), .CH_WR_PTR_I(wr_ptr), .CH_WR_CNT_I(wr_cnt), .CH_WDATA_I(wdata),
    .CH_WIDE_I(wide), .CH_PTR_O(ptr), .CH_CNT_O(cnt), .CH_END_O(end_f), .PER_REQ_I(req),
    .PER_RDATA_I(prd), .PER_ACK_O(ack), .PER_WDATA_O(pwd), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
    .MEM_WIDE_O(mwide), .MEM_ADDR_O(madr), .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .MEM_ACK_I(mack));
  ptc_mem_model ptc_mem_model_i (.clk_i(clk), .rstn_i(rstn), .lat_i(lat), .req_i(mreq),
    .we_i(mwe), .wide_i(mwide), .addr_i(madr), .wdata_i(mwd), .rdata_o(mrd), .ack_o(mack),
    .wr_addr_o(w_adr), .wr_data_o(w_dat), .wr_wide_o(w_wide), .n_wr_o(n_wr));
  // clock and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input int ch, input logic is_cnt, input logic [31:0] v);
    @(negedge clk);
    wdata = v;
    if (is_cnt) wr_cnt[ch] = 1'b1; else wr_ptr[ch] = 1'b1;
    @(negedge clk);
    wr_cnt = '0;
    wr_ptr = '0;
  endtask
  // one item: request until the one-cycle ack, then drop
  task automatic item(input int ch);
    @(negedge clk);
    req[ch] = 1'b1;
    for (k = 0; k < 200 && ack[ch] !== 1'b1; k++) @(negedge clk);
    req[ch] = 1'b0;
    check("ack wait", k < 200, 1'b1);
  endtask
  task automatic idle();
    repeat (2) @(negedge clk);
    for (k = 0; k < 200 && mreq !== 1'b0; k++) @(negedge clk);
    check("idle wait", k < 200, 1'b1);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    check("reset out", {end_f, ack, mreq}, 32'h0);
    check("reset count", cnt[7], 32'h0);
    rstn = 1'b1;
    // every channel, rx even and tx odd, latency growing
    for (int c = 0; c < 8; c++) begin
      base = 32'h0001_0000 | (32'(c) << 8);
      step = wide[c] ? 32'h2 : 32'h1;
      lat = 4'(c);
      prd[c/2] = 16'hC3A0 + 16'(c);
      reg_wr(c, 1'b0, base);
      reg_wr(c, 1'b1, 32'h0000_0002);
      check("count", cnt[c], 16'h0002);
      check("end low", end_f[c], 1'b0);
      item(c);
      item(c);
      idle();
      check("pointer", ptr[c], base + 2 * step);
      check("count 0", cnt[c], 16'h0000);
      check("end high", end_f[c], 1'b1);
      if (c % 2 == 0) begin
        check("mem addr", w_adr, base + step);
        check("mem data", w_dat, prd[c/2]);
        check("mem wide", w_wide, wide[c]);
      end else check("tx data", pwd, 16'(~(base[15:0] + step[15:0])));
      check("write count", n_wr, 32'(2 * (c / 2 + 1)));
    end
    // empty channel ignores a held request
    reg_wr(2, 1'b1, 32'h0000_0005);
    check("end cleared", end_f[2], 1'b0);
    reg_wr(2, 1'b1, 32'h0);
    check("end zero", end_f[2], 1'b1);
    req[0] = 1'b1;
    repeat (10) @(negedge clk) check("no ack", {ack[0], mreq}, 2'b00);
    // slow memory with four channels at once stalls the buffer
    lat = 4'hC;
    n0 = n_wr;
    for (int c = 0; c < 8; c += 2) reg_wr(c, 1'b1, 32'h0000_0001);
    req = 8'h55;
    for (k = 0; k < 400 && (end_f & 8'h55) !== 8'h55; k++) @(negedge clk);
    req = '0;
    idle();
    check("writes", 8'(n_wr - n0), 8'h04);
    stop_test();
  end
endmodule
`default_nettype wire
